// ### hw/system_clock_source_select.sv
// system clock source selector with prescaler and glitch-free switching
//
// How it works
// - with select 11 the system clock follows the direct clock input.
// - in direct drive the high and low times follow the input's duty.
// - prescaler mode from the crystal with factor 1 acts as direct drive.
// - select 10 with pll bypass 1 divides the oscillator by the factor.
// - the prescaler input is the crystal or the internal clock source.
// - the factor is the divide field plus one; factor 1 passes through.
// - the largest factor is 1024, giving the slowest prescaled clock.
// - select 10 with pll bypass 0 enables the pll and uses its output.
// - select 00 takes the system clock from the wakeup clock source.
`timescale 1ns/100ps
`default_nettype none
module system_clock_source_select
   import clk_sel_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   // clock pins and source outputs
   input  wire logic                  direct_clock_input_i,
   input  wire logic                  crystal_input_i,
   input  wire logic                  internal_clock_i,
   input  wire logic                  wakeup_clock_i,
   input  wire logic                  pll_clock_i,
   // configuration from software logic
   input  wire clk_sel_pkg::clk_cfg_s cfg_i,
   // system clock and status
   output logic                       sys_clk_o,
   output logic                       pll_enable_o,
   output logic                       switch_busy_o,
   output clk_sel_pkg::clk_cfg_s      active_cfg_o
);
   import clk_sel_pkg::*;

   // each pin or source clock passes two flops; sources must run below a
   // quarter of the core clock, and the output has a one-cycle grain
   logic [NUM_SRC-1:0] src_raw;
   logic [NUM_SRC-1:0] src_sync;

   assign src_raw[SRC_DIRECT]   = direct_clock_input_i;
   assign src_raw[SRC_CRYSTAL]  = crystal_input_i;
   assign src_raw[SRC_INTERNAL] = internal_clock_i;
   assign src_raw[SRC_WAKEUP]   = wakeup_clock_i;
   assign src_raw[SRC_PLL]      = pll_clock_i;

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_sync
         pin_sync u_sync (
            .core_clk_i (core_clk_i),
            .nrst_i     (nrst_i),
            .async_i    (src_raw[g]),
            .sync_o     (src_sync[g])
         );
      end
   endgenerate

   // switching state
   sw_state_e        state;
   sw_state_e        next_state;
   clk_cfg_s         active;
   clk_cfg_s         next_active;
   logic             next_sys_clk;
   logic             next_pll_enable;
   logic             next_switch_busy;
   logic             div_clear;

   // divider state
   logic             level_prev;
   logic             next_level_prev;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             div_high;
   logic             next_div_high;

   // decoded view of the active setting
   logic             use_div;
   logic             src_level;
   logic             src_out;
   logic             rise;
   logic [CNT_W-1:0] factor;
   logic [CNT_W-1:0] half;

   // source level and output of the active setting
   always_comb begin
      use_div   = 1'b0;
      src_level = 1'b0;
      case (active.clock_source_select)
         SEL_DIRECT: begin
            src_level = src_sync[SRC_DIRECT];
         end
         SEL_OSC_PLL: begin
            if (active.pll_bypass_bit) begin
               use_div = 1'b1;
               src_level = active.osc_from_internal ?
                           src_sync[SRC_INTERNAL] :
                           src_sync[SRC_CRYSTAL];
            end else begin
               src_level = src_sync[SRC_PLL];
            end
         end
         SEL_WAKEUP: begin
            src_level = src_sync[SRC_WAKEUP];
         end
         default: begin
            // reserved code: output held low
            src_level = 1'b0;
         end
      endcase
      // factor = field + 1, reaching 1024 at the largest field value
      factor = {1'b0, active.prescaler_divide_field} + 11'h001;
      half   = (factor + 11'h001) >> 1;
      rise   = src_level & ~level_prev;
      // factor 1 and undivided modes pass the level and its duty unchanged
      if (use_div && factor != 11'h001) begin
         src_out = div_high;
      end else begin
         src_out = src_level;
      end
   end

   // divider advances only on source rising edges, so no short phase
   always_comb begin
      next_level_prev = src_level;
      next_cnt        = cnt;
      next_div_high   = div_high;
      if (div_clear) begin
         // restart from a low output so the first high is full
         next_cnt      = CNT_RESET;
         next_div_high = 1'b0;
      end else if (rise) begin
         // high from count 0 up to count half: ceil(factor/2) periods
         if (cnt == CNT_RESET) begin
            next_div_high = 1'b1;
         end
         if (cnt == half) begin
            next_div_high = 1'b0;
         end
         if (cnt + 11'h001 >= factor) begin
            next_cnt = CNT_RESET;
         end else begin
            next_cnt = cnt + 11'h001;
         end
      end
   end

   // switch: drain the old high phase, swap, arm on a low new source
   always_comb begin
      next_state   = state;
      next_active  = active;
      next_sys_clk = sys_clk_o;
      div_clear    = 1'b0;
      case (state)
         ST_RUN: begin
            next_sys_clk = src_out;
            if (cfg_i != active) begin
               next_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // finish the running high phase, then hold low
            next_sys_clk = src_out;
            if (!src_out) begin
               next_state  = ST_ARM;
               next_active = cfg_i;
               div_clear   = 1'b1;
            end
         end
         ST_ARM: begin
            // held low until the new source is low, so its first high is full
            next_sys_clk = 1'b0;
            div_clear    = 1'b1;
            if (!src_level) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state   = ST_ARM;
            next_sys_clk = 1'b0;
            div_clear    = 1'b1;
         end
      endcase
      next_pll_enable  = (next_active.clock_source_select == SEL_OSC_PLL) &&
                         !next_active.pll_bypass_bit;
      next_switch_busy = (next_state != ST_RUN);
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         level_prev <= 1'b0;
         cnt        <= CNT_RESET;
         div_high   <= 1'b0;
      end else begin
         level_prev <= next_level_prev;
         cnt        <= next_cnt;
         div_high   <= next_div_high;
      end
   end

   // outputs come straight from these flops
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state         <= ST_ARM;
         active        <= CFG_RESET;
         sys_clk_o     <= 1'b0;
         pll_enable_o  <= 1'b0;
         switch_busy_o <= 1'b1;
         active_cfg_o  <= CFG_RESET;
      end else begin
         state         <= next_state;
         active        <= next_active;
         sys_clk_o     <= next_sys_clk;
         pll_enable_o  <= next_pll_enable;
         switch_busy_o <= next_switch_busy;
         active_cfg_o  <= next_active;
      end
   end
endmodule
`default_nettype wire

// ### hw/clk_sel_pkg.sv
// constants and types shared by the system clock selector
package clk_sel_pkg;

   // selection codes of the clock source select field
   localparam logic [1:0] SEL_WAKEUP    = 2'h0;
   localparam logic [1:0] SEL_RESERVED  = 2'h1;
   localparam logic [1:0] SEL_OSC_PLL   = 2'h2;
   localparam logic [1:0] SEL_DIRECT    = 2'h3;

   // prescaler divide field: factor is field value plus one, 1..1024
   localparam int         DIV_W         = 10;
   localparam int         CNT_W         = 11;
   localparam logic [CNT_W-1:0] DIV_MAX_FACTOR = 11'h400;

   // clock pins and source outputs sampled by the selector
   localparam int         NUM_SRC       = 5;
   localparam int         SRC_DIRECT    = 0;
   localparam int         SRC_CRYSTAL   = 1;
   localparam int         SRC_INTERNAL  = 2;
   localparam int         SRC_WAKEUP    = 3;
   localparam int         SRC_PLL       = 4;

   // selection and prescaler settings as one word
   typedef struct packed {
      logic [1:0]       clock_source_select;
      logic             pll_bypass_bit;
      logic             osc_from_internal;
      logic [DIV_W-1:0] prescaler_divide_field;
   } clk_cfg_s;

   // values after reset: run from the wakeup source, undivided
   localparam clk_cfg_s   CFG_RESET     = '{SEL_WAKEUP, 1'b1, 1'b0, 10'h000};
   localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_DRAIN = 2'b01,
      ST_ARM   = 2'b10
   } sw_state_e;

endpackage

// ### hw/pin_sync.sv
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   // level in and out
   input  wire logic async_i,
   output logic      sync_o
);
   logic stage1;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule
`default_nettype wire

// ### verification/clk_sel_assertions.sv
// concurrent checks on the ports of the system clock selector
`timescale 1ns/100ps
`default_nettype none
module clk_sel_checker
   import clk_sel_pkg::*;
(
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   // clock pins and source outputs
   input  wire logic                  direct_clock_input_i,
   input  wire logic                  crystal_input_i,
   input  wire logic                  internal_clock_i,
   input  wire logic                  wakeup_clock_i,
   input  wire logic                  pll_clock_i,
   // configuration, system clock and status
   input  wire clk_sel_pkg::clk_cfg_s cfg_i,
   input  wire logic                  sys_clk_o,
   input  wire logic                  pll_enable_o,
   input  wire logic                  switch_busy_o,
   input  wire clk_sel_pkg::clk_cfg_s active_cfg_o
);
   import clk_sel_pkg::*;
   wire logic [1:0] sel = active_cfg_o.clock_source_select;
   wire logic       byp = active_cfg_o.pll_bypass_bit;
   wire logic       k1  = active_cfg_o.prescaler_divide_field == 10'h000;
   wire logic       xin = active_cfg_o.osc_from_internal;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   reset_state_a: assert property (
      $rose(nrst_i) |-> active_cfg_o == CFG_RESET && switch_busy_o)
      else $error("setting after reset is not the wakeup default");
   take_switch_a: assert property (
      !switch_busy_o && cfg_i != active_cfg_o |=> switch_busy_o)
      else $error("new setting not taken up");
   swap_quiet_a: assert property (
      $changed(active_cfg_o) |-> !sys_clk_o && switch_busy_o)
      else $error("setting changed while clock high or idle");
   pll_enable_a: assert property (
      !switch_busy_o |-> pll_enable_o == (sel == SEL_OSC_PLL && !byp))
      else $error("pll enable does not match setting");
   direct_follow_a: assert property (
      !switch_busy_o [*4] ##0 sel == SEL_DIRECT
      |-> sys_clk_o == $past(direct_clock_input_i, 3))
      else $error("system clock does not follow direct input");
   wakeup_follow_a: assert property (
      !switch_busy_o [*4] ##0 sel == SEL_WAKEUP
      |-> sys_clk_o == $past(wakeup_clock_i, 3))
      else $error("system clock does not follow wakeup source");
   pll_follow_a: assert property (
      !switch_busy_o [*4] ##0 sel == SEL_OSC_PLL && !byp
      |-> sys_clk_o == $past(pll_clock_i, 3))
      else $error("system clock does not follow pll output");
   osc_pass_a: assert property (
      !switch_busy_o [*4] ##0 sel == SEL_OSC_PLL && byp && k1 && !xin
      |-> sys_clk_o == $past(crystal_input_i, 3))
      else $error("factor one does not pass the crystal clock");
endmodule
bind system_clock_source_select clk_sel_checker u_clk_sel_checker (
   .core_clk_i, .nrst_i, .direct_clock_input_i, .crystal_input_i,
   .internal_clock_i, .wakeup_clock_i, .pll_clock_i, .cfg_i, .sys_clk_o,
   .pll_enable_o, .switch_busy_o, .active_cfg_o);
`default_nettype wire

// ### verification/ext_clock_gen.sv
// external clock generator: free-running source clocks for the selector
`timescale 1ns/100ps
`default_nettype none
module ext_clock_gen #(
   parameter int HI [5] = '{default: 4},
   parameter int LO [5] = '{default: 4}
) (
   // source clocks, high and low times in 25 ns steps
   output wire logic [4:0] clk_o
);
   for (genvar g = 0; g < 5; g++) begin : gen_src
      logic clk;
      assign clk_o[g] = clk;
      // offset keeps source edges away from the core clock edges
      initial begin
         clk = 1'b0;
         #3;
         forever begin
            clk = 1'b1;
            #(HI[g] * 25);
            clk = 1'b0;
            #(LO[g] * 25);
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the system clock selector
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import clk_sel_pkg::*;
   localparam int HI [5] = '{10, 4, 6, 9, 5};
   localparam int LO [5] = '{20, 4, 6, 11, 7};
   localparam int XP     = HI[SRC_CRYSTAL] + LO[SRC_CRYSTAL];
   localparam int IP     = HI[SRC_INTERNAL] + LO[SRC_INTERNAL];
   logic       core_clk_i = 1'b0;
   logic       nrst_i     = 1'b0;
   logic [4:0] src;
   clk_cfg_s   cfg_i      = CFG_RESET;
   logic       sys_clk_o;
   logic       pll_enable_o;
   logic       switch_busy_o;
   clk_cfg_s   active_cfg_o;
   int         n_errors   = 0;
   int         checked    = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   ext_clock_gen #(.HI(HI), .LO(LO)) u_ext_clock_gen (.clk_o(src));
   system_clock_source_select u_system_clock_source_select (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .direct_clock_input_i(src[SRC_DIRECT]),
      .crystal_input_i(src[SRC_CRYSTAL]),
      .internal_clock_i(src[SRC_INTERNAL]),
      .wakeup_clock_i(src[SRC_WAKEUP]), .pll_clock_i(src[SRC_PLL]),
      .cfg_i(cfg_i), .sys_clk_o(sys_clk_o), .pll_enable_o(pll_enable_o),
      .switch_busy_o(switch_busy_o), .active_cfg_o(active_cfg_o));

   task automatic check_int(input string what, input int exp, input int got);
      checked++;
      if (exp != got) begin
         n_errors++;
         $display("wrong value %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask
   task automatic check_val(input string what, input logic [13:0] exp,
                            input logic [13:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // length of the next full high phase and the low phase after it
   task automatic measure(input int eh, input int el);
      int t = 0;
      int h = 0;
      int l = 0;
      while (sys_clk_o !== 1'b1 && t < 9000) @(negedge core_clk_i) t++;
      while (sys_clk_o === 1'b1 && h < 9000) @(negedge core_clk_i) h++;
      while (sys_clk_o === 1'b0 && l < 9000) @(negedge core_clk_i) l++;
      check_int("high cycles", eh, h);
      check_int("low cycles", el, l);
   endtask
   task automatic switch_to(input clk_cfg_s c);
      int t = 0;
      @(negedge core_clk_i);
      cfg_i = c;
      repeat (2) @(negedge core_clk_i);
      while (switch_busy_o !== 1'b0 && t < 9000) @(negedge core_clk_i) t++;
      check_val("active setting", c, active_cfg_o);
   endtask
   task automatic s_wakeup;
      @(negedge core_clk_i);
      cfg_i = CFG_RESET;
      nrst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      check_val("reset setting", CFG_RESET, active_cfg_o);
      check_val("clock in reset", 14'h0, 14'(sys_clk_o));
      nrst_i = 1'b1;
      measure(HI[SRC_WAKEUP], LO[SRC_WAKEUP]);
   endtask
   task automatic s_direct;
      switch_to('{SEL_DIRECT, 1'b1, 1'b0, 10'h000});
      check_val("pll enable", 14'h0, 14'(pll_enable_o));
      measure(HI[SRC_DIRECT], LO[SRC_DIRECT]);
   endtask
   task automatic s_pll;
      switch_to('{SEL_OSC_PLL, 1'b0, 1'b0, 10'h000});
      check_val("pll enable", 14'h1, 14'(pll_enable_o));
      measure(HI[SRC_PLL], LO[SRC_PLL]);
   endtask
   task automatic s_reserved;
      int n = 0;
      switch_to('{SEL_RESERVED, 1'b1, 1'b0, 10'h000});
      check_val("pll enable", 14'h0, 14'(pll_enable_o));
      repeat (40) begin
         @(negedge core_clk_i);
         if (sys_clk_o !== 1'b0) n++;
      end
      check_int("reserved clock highs", 0, n);
   endtask
   task automatic s_prescale;
      switch_to('{SEL_OSC_PLL, 1'b1, 1'b0, 10'h000});
      measure(HI[SRC_CRYSTAL], LO[SRC_CRYSTAL]);
      switch_to('{SEL_OSC_PLL, 1'b1, 1'b0, 10'h002});
      measure((3 + 1) / 2 * XP, 3 / 2 * XP);
      switch_to('{SEL_OSC_PLL, 1'b1, 1'b1, 10'h001});
      measure(IP, IP);
      switch_to('{SEL_OSC_PLL, 1'b1, 1'b0, 10'h3ff});
      measure(1024 / 2 * XP, 1024 / 2 * XP);
   endtask
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge core_clk_i);
      nrst_i = 1'b1;
      s_wakeup();
      s_direct();
      s_pll();
      s_reserved();
      s_prescale();
      s_wakeup();
      finish_test();
   end
   // the whole run needs about 8600 core cycles
   initial begin
      #1500000;
      n_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
